// [rtl/fecr_params.svh]
// offsets, field positions, reset values and timing counts for the fan enhancement block
`ifndef FECR_PARAMS_SVH
`define FECR_PARAMS_SVH

`define FECR_ADDR_ENH        8'h45
`define FECR_BIT_RSVD        7
`define FECR_BIT_FINE_EN     6
`define FECR_BIT_LUT_RES     5
`define FECR_BIT_DUTY_FINE   4
`define FECR_BIT_USIGN       3
`define FECR_BIT_RATE_HI     2
`define FECR_BIT_RATE_LO     1
`define FECR_BIT_RAMP_EN     0
`define FECR_ENH_RESET       8'h00
`define FECR_CLK_HZ          40000000
// ramp intervals in microseconds, code 10 taken as 0.091 s
`define FECR_T_RATE0_US      23000
`define FECR_T_RATE1_US      46000
`define FECR_T_RATE2_US      91000
`define FECR_T_RATE3_US      182000
`define FECR_US_PER_S        1000000
`define FECR_COARSE_STEP     8'h10
`define FECR_FINE_STEP       8'h01

`endif

// [rtl/fecr_pkg.sv]
// types shared by the fan enhancement block
package fecr_pkg;

  // decoded fields of the enhancement control register
  typedef struct packed {
    logic       fine_bits_en;
    logic       lut_res_ext;
    logic       duty_fine;
    logic       setpoint_unsigned;
    logic [1:0] ramp_interval;
    logic       ramp_en;
  } fecr_ctrl_t;

  typedef enum logic [1:0] {
    FECR_DUTY_IDLE = 2'b00,
    FECR_DUTY_RAMP = 2'b01,
    FECR_DUTY_JUMP = 2'b10
  } fecr_duty_state_t;

endpackage : fecr_pkg

// [rtl/fecr_ramp_timer.sv]
// divider giving one-cycle pulses at the selected ramp interval
`timescale 1ns/1ps
`include "fecr_params.svh"

module fecr_ramp_timer #(
  parameter int unsigned CLK_HZ = `FECR_CLK_HZ,
  parameter int unsigned T0_US  = `FECR_T_RATE0_US,
  parameter int unsigned T1_US  = `FECR_T_RATE1_US,
  parameter int unsigned T2_US  = `FECR_T_RATE2_US,
  parameter int unsigned T3_US  = `FECR_T_RATE3_US
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  // tick out
  output logic            tick_o
);

  // each time rounds down, never below one cycle
  localparam longint unsigned C0 = (longint'(CLK_HZ) * T0_US) / `FECR_US_PER_S;
  localparam longint unsigned C1 = (longint'(CLK_HZ) * T1_US) / `FECR_US_PER_S;
  localparam longint unsigned C2 = (longint'(CLK_HZ) * T2_US) / `FECR_US_PER_S;
  localparam longint unsigned C3 = (longint'(CLK_HZ) * T3_US) / `FECR_US_PER_S;
  localparam logic [23:0] N0 = (C0 < 1) ? 24'h000001 : C0[23:0];
  localparam logic [23:0] N1 = (C1 < 1) ? 24'h000001 : C1[23:0];
  localparam logic [23:0] N2 = (C2 < 1) ? 24'h000001 : C2[23:0];
  localparam logic [23:0] N3 = (C3 < 1) ? 24'h000001 : C3[23:0];

  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  wire  [23:0] limit = (sel_i == 2'b00) ? N0 :
                       (sel_i == 2'b01) ? N1 :
                       (sel_i == 2'b10) ? N2 : N3;
  wire         last  = (cnt_reg >= limit - 24'h000001);

  // count restarts whenever run_i drops
  assign cnt_next = (!run_i || last) ? 24'h000000 : cnt_reg + 24'h000001;
  assign tick_o   = run_i && last;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_reg <= 24'h000000;
    else
      cnt_reg <= cnt_next;
  end

endmodule : fecr_ramp_timer

// [rtl/fecr_duty_ramp.sv]
// duty tracker that walks toward the table target or jumps
`timescale 1ns/1ps
`include "fecr_params.svh"

module fecr_duty_ramp (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       smooth_i,
  input  wire logic       fine_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] target_i,
  // duty out
  output logic [7:0]      duty_o,
  output logic            ramping_o
);

  fecr_pkg::fecr_duty_state_t state_reg;
  fecr_pkg::fecr_duty_state_t state_next;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;

  wire [7:0] step    = fine_i ? `FECR_FINE_STEP : `FECR_COARSE_STEP;
  wire [8:0] up_sum  = {1'b0, duty_reg} + {1'b0, step};
  wire       go_up   = target_i > duty_reg;
  wire       near_up = (target_i - duty_reg) <= step;
  wire       near_dn = (duty_reg - target_i) <= step;
  wire [7:0] stepped = go_up ? (near_up ? target_i : up_sum[7:0])
                             : (near_dn ? target_i : duty_reg - step);

  // state selection: equal means done, not smoothing means jump
  always_comb
  begin
    state_next = fecr_pkg::FECR_DUTY_IDLE;
    duty_next  = duty_reg;
    case (state_reg)
      fecr_pkg::FECR_DUTY_IDLE,
      fecr_pkg::FECR_DUTY_RAMP,
      fecr_pkg::FECR_DUTY_JUMP:
      begin
        if (target_i == duty_reg)
          state_next = fecr_pkg::FECR_DUTY_IDLE;
        else if (!smooth_i)
        begin
          state_next = fecr_pkg::FECR_DUTY_JUMP;
          duty_next  = target_i;
        end
        else
        begin
          state_next = fecr_pkg::FECR_DUTY_RAMP;
          if (tick_i)
            duty_next = stepped;
        end
      end
      default:
      begin
        state_next = fecr_pkg::FECR_DUTY_IDLE;
        duty_next  = target_i;
      end
    endcase
  end

  assign duty_o    = duty_reg;
  assign ramping_o = (state_reg == fecr_pkg::FECR_DUTY_RAMP);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= fecr_pkg::FECR_DUTY_IDLE;
      duty_reg  <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      duty_reg  <= duty_next;
    end
  end

endmodule : fecr_duty_ramp

// [rtl/fecr_enh_ctrl.sv]
// fan enhancement control register and the behaviour it drives
`timescale 1ns/1ps
`include "fecr_params.svh"

module fecr_enh_ctrl #(
  // clock rate the ramp intervals are counted in
  parameter int unsigned CLK_HZ = `FECR_CLK_HZ
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // register access port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  output logic [7:0]       reg_rdata_o,
  // device state
  input  wire logic        pwm_program_unlock_i,
  input  wire logic        pwm_freq_22k5_i,
  input  wire logic        spin_up_i,
  input  wire logic        critical_temperature_event_i,
  input  wire logic        filter_active_i,
  // remote temperature low byte
  input  wire logic [7:0]  remote_low_raw_i,
  output logic [7:0]       remote_low_o,
  // setpoint comparison
  input  wire logic [10:0] remote_temp_i,
  input  wire logic [10:0] high_setpoint_i,
  input  wire logic [10:0] critical_temperature_limit_i,
  output logic             high_exceeded_o,
  output logic             critical_exceeded_o,
  // duty path
  input  wire logic [7:0]  lut_duty_i,
  input  wire logic [7:0]  program_duty_i,
  input  wire logic [7:0]  override_duty_i,
  output logic [7:0]       duty_o,
  output logic             ramping_o,
  // decoded configuration
  output fecr_pkg::fecr_ctrl_t ctrl_o
);

  logic [7:0] enh_reg;
  logic [7:0] enh_next;
  logic       hi_reg;
  logic       crit_reg;
  logic [7:0] low_reg;
  logic       tick;

  // signed compare flips the top bits so an unsigned compare works
  function automatic logic above(input logic [10:0] t, input logic [10:0] s,
                                 input logic uns);
    logic [10:0] ta;
    logic [10:0] sa;
    ta = uns ? t : {~t[10], t[9:0]};
    sa = uns ? s : {~s[10], s[9:0]};
    above = ta > sa;
  endfunction : above

  wire wr_hit = reg_wr_i && (reg_addr_i == `FECR_ADDR_ENH);
  wire [2:0] ramp_bits_next = pwm_program_unlock_i ?
                              reg_wdata_i[`FECR_BIT_RATE_HI:`FECR_BIT_RAMP_EN] :
                              enh_reg[`FECR_BIT_RATE_HI:`FECR_BIT_RAMP_EN];

  // write merge: top bit dropped, low three gated by unlock
  assign enh_next = wr_hit ?
                    {1'b0, reg_wdata_i[`FECR_BIT_FINE_EN:`FECR_BIT_USIGN], ramp_bits_next}
                    : enh_reg;

  assign ctrl_o.fine_bits_en      = enh_reg[`FECR_BIT_FINE_EN];
  assign ctrl_o.lut_res_ext       = enh_reg[`FECR_BIT_LUT_RES];
  assign ctrl_o.duty_fine         = enh_reg[`FECR_BIT_DUTY_FINE] && pwm_freq_22k5_i;
  assign ctrl_o.setpoint_unsigned = enh_reg[`FECR_BIT_USIGN];
  assign ctrl_o.ramp_interval     = enh_reg[`FECR_BIT_RATE_HI:`FECR_BIT_RATE_LO];
  assign ctrl_o.ramp_en           = enh_reg[`FECR_BIT_RAMP_EN];

  // fine fraction bits shown only when enabled and filtered
  wire       show_fine = ctrl_o.fine_bits_en && filter_active_i;
  wire [7:0] low_next  = {remote_low_raw_i[7:5],
                          show_fine ? remote_low_raw_i[4:3] : 2'b00,
                          remote_low_raw_i[2:0]};

  // comparisons against the high and critical limits
  wire hi_next   = above(remote_temp_i, high_setpoint_i, ctrl_o.setpoint_unsigned);
  wire crit_next = above(remote_temp_i, critical_temperature_limit_i,
                         ctrl_o.setpoint_unsigned);

  // duty source: override and program writes bypass the table path
  wire bypass = spin_up_i || critical_temperature_event_i;
  wire table_mode = !pwm_program_unlock_i && !bypass;
  wire [7:0] target = bypass ? override_duty_i :
                      (pwm_program_unlock_i ? program_duty_i : lut_duty_i);
  wire smooth = ctrl_o.ramp_en && pwm_freq_22k5_i && table_mode;

  fecr_ramp_timer #(
    .CLK_HZ  (CLK_HZ)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (smooth),
    .sel_i   (ctrl_o.ramp_interval),
    .tick_o  (tick)
  );

  fecr_duty_ramp u_ramp (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .smooth_i  (smooth),
    .fine_i    (ctrl_o.duty_fine),
    .tick_i    (tick),
    .target_i  (target),
    .duty_o    (duty_o),
    .ramping_o (ramping_o)
  );

  // register state and registered outputs
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      enh_reg  <= `FECR_ENH_RESET;
      hi_reg   <= 1'b0;
      crit_reg <= 1'b0;
      low_reg  <= 8'h00;
    end
    else
    begin
      enh_reg  <= enh_next;
      hi_reg   <= hi_next;
      crit_reg <= crit_next;
      low_reg  <= low_next;
    end
  end

  // read mux, unmapped addresses return zero; top bit always zero
  assign reg_rdata_o = (reg_addr_i == `FECR_ADDR_ENH) ?
                       {1'b0, enh_reg[`FECR_BIT_FINE_EN:0]} : 8'h00;
  assign remote_low_o        = low_reg;
  assign high_exceeded_o     = hi_reg;
  assign critical_exceeded_o = crit_reg;

endmodule : fecr_enh_ctrl

// [verif/fecr_enh_checker.sv]
// assertion checker for the fan enhancement control block
`timescale 1ns/1ps
module fecr_enh_checker (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  // register access and device state
  input wire logic [7:0]           reg_addr_i,
  input wire logic [7:0]           reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic [7:0]           reg_rdata_o,
  input wire logic                 pwm_program_unlock_i,
  input wire logic                 pwm_freq_22k5_i,
  input wire logic                 spin_up_i,
  input wire logic                 critical_temperature_event_i,
  input wire logic                 filter_active_i,
  // data paths
  input wire logic [7:0]           remote_low_raw_i,
  input wire logic [7:0]           remote_low_o,
  input wire logic [10:0]          remote_temp_i,
  input wire logic [10:0]          critical_temperature_limit_i,
  input wire logic                 critical_exceeded_o,
  input wire logic [7:0]           lut_duty_i,
  input wire logic [7:0]           override_duty_i,
  input wire logic [7:0]           duty_o,
  input wire logic                 ramping_o,
  input wire fecr_pkg::fecr_ctrl_t ctrl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // smoothing allowed only for table driven changes at 22.5kHz
  wire smooth = ctrl_o.ramp_en && pwm_freq_22k5_i && !pwm_program_unlock_i
                && !spin_up_i && !critical_temperature_event_i;
  wire fine_on = ctrl_o.fine_bits_en && filter_active_i;
  wire enh_wr  = reg_wr_i && (reg_addr_i == 8'h45);
  sequence s_far_target;
    smooth && (lut_duty_i != duty_o);
  endsequence
  property p_rsvd; reg_rdata_o[7] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
  property p_mask; !fine_on |=> remote_low_o[4:3] == 2'h0; endproperty
  a_mask: assert property (p_mask) else $error("fine bits not masked");
  property p_pass; fine_on |=> remote_low_o[4:3] == $past(remote_low_raw_i[4:3]); endproperty
  a_pass: assert property (p_pass) else $error("fine bits not shown");
  property p_lock;
    enh_wr && !pwm_program_unlock_i |=> $stable(ctrl_o.ramp_en) && $stable(ctrl_o.ramp_interval);
  endproperty
  a_lock: assert property (p_lock) else $error("locked ramp bits changed");
  property p_wr;
    enh_wr && pwm_program_unlock_i |=> {ctrl_o.ramp_interval, ctrl_o.ramp_en}
      == $past(reg_wdata_i[2:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("ramp bits not written");
  property p_crit;
    ##1 critical_exceeded_o == ($past(ctrl_o.setpoint_unsigned)
      ? ($past(remote_temp_i) > $past(critical_temperature_limit_i))
      : ($signed($past(remote_temp_i)) > $signed($past(critical_temperature_limit_i))));
  endproperty
  a_crit: assert property (p_crit) else $error("critical compare wrong");
  property p_ovr; spin_up_i || critical_temperature_event_i |=> duty_o == $past(override_duty_i);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not direct");
  property p_freq;
    !pwm_freq_22k5_i && !pwm_program_unlock_i && !spin_up_i && !critical_temperature_event_i
      |=> duty_o == $past(lut_duty_i);
  endproperty
  a_freq: assert property (p_freq) else $error("duty ramped off 22.5kHz");
  property p_ramp; s_far_target ##1 s_far_target |-> ramping_o; endproperty
  a_ramp: assert property (p_ramp) else $error("no ramp toward target");
  property p_fine;
    reg_addr_i == 8'h45 |-> ctrl_o.duty_fine == (reg_rdata_o[4] && pwm_freq_22k5_i);
  endproperty
  a_fine: assert property (p_fine) else $error("fine duty off 22.5kHz");
endmodule : fecr_enh_checker

bind fecr_enh_ctrl fecr_enh_checker i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rdata_o(reg_rdata_o), .pwm_program_unlock_i(pwm_program_unlock_i),
  .pwm_freq_22k5_i(pwm_freq_22k5_i), .spin_up_i(spin_up_i),
  .critical_temperature_event_i(critical_temperature_event_i),
  .filter_active_i(filter_active_i), .remote_low_raw_i(remote_low_raw_i),
  .remote_low_o(remote_low_o), .remote_temp_i(remote_temp_i),
  .critical_temperature_limit_i(critical_temperature_limit_i),
  .critical_exceeded_o(critical_exceeded_o), .lut_duty_i(lut_duty_i),
  .override_duty_i(override_duty_i), .duty_o(duty_o), .ramping_o(ramping_o), .ctrl_o(ctrl_o));

// [verif/tb_fan_enhanced_config_and_ramp.sv]
// self-checking bench for the fan enhancement control block
`timescale 1ns/1ps
module tb_fan_enhanced_config_and_ramp;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, unl = 1'b1, f22 = 1'b0, spin = 1'b0;
  logic crit = 1'b0, filt = 1'b0, hi, cr, ramping;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, raw = 8'hFF, low, lut = 8'h00;
  logic [7:0] prog = 8'h00, ovr = 8'h00, duty;
  logic [10:0] temp = 11'h400, lim = 11'h100;
  fecr_pkg::fecr_ctrl_t ctrl;
  int err_total = 0, tests_run = 0;
  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;
  // timer counted at 1 kHz: intervals of 23, 46, 91 and 182 cycles
  fecr_enh_ctrl #(.CLK_HZ(1000)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata), .pwm_program_unlock_i(unl),
    .pwm_freq_22k5_i(f22), .spin_up_i(spin), .critical_temperature_event_i(crit),
    .filter_active_i(filt), .remote_low_raw_i(raw), .remote_low_o(low),
    .remote_temp_i(temp), .high_setpoint_i(lim), .critical_temperature_limit_i(lim),
    .high_exceeded_o(hi), .critical_exceeded_o(cr), .lut_duty_i(lut),
    .program_duty_i(prog), .override_duty_i(ovr), .duty_o(duty), .ramping_o(ramping),
    .ctrl_o(ctrl));
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe, launched off the sampling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr = a;
    #1 chk("rdata", exp, rdata);
  endtask : rd_reg
  // settle two registered cycles then look
  task automatic step;
    @(negedge clk_i);
    @(negedge clk_i);
  endtask : step
  // hang guard well above the test's run time
  initial
  begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd_reg(8'h45, 8'h00);
    rd_reg(8'h46, 8'h00);
    wr_reg(8'h45, 8'hFF);
    rd_reg(8'h45, 8'h7F);
    chk("fine off 22k5", 8'h00, {7'h00, ctrl.duty_fine});
    chk("lut res", 8'h01, {7'h00, ctrl.lut_res_ext});
    unl = 1'b0;
    wr_reg(8'h45, 8'h00);
    rd_reg(8'h45, 8'h07);
    unl = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h45, 8'h10 | 8'(c << 1) | 8'h01);
      chk("interval", 8'(c), {6'h00, ctrl.ramp_interval});
    end
    f22 = 1'b1;
    #1 chk("fine at 22k5", 8'h01, {7'h00, ctrl.duty_fine});
    wr_reg(8'h45, 8'h08);
    step();
    chk("low masked", 8'hE7, low);
    chk("crit unsigned", 8'h01, {7'h00, cr});
    chk("high unsigned", 8'h01, {7'h00, hi});
    wr_reg(8'h45, 8'h41);
    filt = 1'b1;
    step();
    chk("low fine", 8'hFF, low);
    chk("crit signed", 8'h00, {7'h00, cr});
    filt = 1'b0;
    prog = 8'h33;
    step();
    chk("low filter off", 8'hE7, low);
    chk("program duty", 8'h33, duty);
    f22 = 1'b0;
    unl = 1'b0;
    lut = 8'h20;
    step();
    chk("jump off 22k5", 8'h20, duty);
    f22 = 1'b1;
    lut = 8'h90;
    repeat (20) @(negedge clk_i);
    chk("ramp holds", 8'h20, duty);
    chk("ramping", 8'h01, {7'h00, ramping});
    // first tick lands on the 23rd edge, then one coarse step every 23 edges
    repeat (3) @(negedge clk_i);
    chk("coarse step", 8'h30, duty);
    repeat (138) @(negedge clk_i);
    chk("ramp end", 8'h90, duty);
    @(negedge clk_i);
    chk("ramp stop", 8'h00, {7'h00, ramping});
    // stop smoothing at target to realign the timer, then take one fine step
    f22 = 1'b0;
    wr_reg(8'h45, 8'h51);
    lut = 8'h80;
    f22 = 1'b1;
    repeat (23) @(negedge clk_i);
    chk("fine step", 8'h8F, duty);
    ovr = 8'h80;
    spin = 1'b1;
    step();
    chk("spin bypass", 8'h80, duty);
    spin = 1'b0;
    crit = 1'b1;
    ovr = 8'hC0;
    step();
    chk("critical bypass", 8'hC0, duty);
    report_and_stop();
  end
endmodule : tb_fan_enhanced_config_and_ramp
